// ### rtl/imru_defs.vh
`ifndef IMRU_DEFS_VH
`define IMRU_DEFS_VH

// Register offsets (byte addresses)
`define IMRU_OFS_MASK_READ      9'h01C
`define IMRU_OFS_PENDING_READ   9'h01E
`define IMRU_OFS_MASK_WRITE     9'h09A
`define IMRU_OFS_PENDING_WRITE  9'h09C

// Field positions
`define IMRU_BIT_POLARITY       15
`define IMRU_BIT_GLOBAL_GATE    14
`define IMRU_BIT_OUTSIDE_LINE   13
`define IMRU_BIT_DISK_MATCH     12
`define IMRU_BIT_SERIAL_RX      11
`define IMRU_BIT_SOUND_HI       10
`define IMRU_BIT_SOUND_LO       7
`define IMRU_BIT_COPIER_DONE    6
`define IMRU_BIT_VBLANK         5
`define IMRU_BIT_COPROC         4
`define IMRU_BIT_IO_TIMER       3
`define IMRU_BIT_SOFT_REQ       2
`define IMRU_BIT_DISK_DONE      1
`define IMRU_BIT_SERIAL_TX      0

// Reset values
`define IMRU_RST_MASK           15'h0000
`define IMRU_RST_PENDING        14'h0000

// Priority levels
`define IMRU_LVL_NONE           3'h0
`define IMRU_LVL_1              3'h1
`define IMRU_LVL_2              3'h2
`define IMRU_LVL_3              3'h3
`define IMRU_LVL_4              3'h4
`define IMRU_LVL_5              3'h5
`define IMRU_LVL_6              3'h6

`endif

// ### rtl/imru_level_encoder.v
`include "imru_defs.vh"

// Maps the active (pending and enabled) request bits to a priority level
module imru_level_encoder (
  input  wire [13:0] active_in,
  input  wire        gate_in,
  output reg  [2:0]  level_out
);

  // Highest group wins; gate low forces level zero
  always @* begin
    level_out = `IMRU_LVL_NONE;
    if (gate_in) begin
      if (active_in[`IMRU_BIT_OUTSIDE_LINE])
        level_out = `IMRU_LVL_6;
      else if (active_in[`IMRU_BIT_DISK_MATCH] | active_in[`IMRU_BIT_SERIAL_RX])
        level_out = `IMRU_LVL_5;
      else if (|active_in[`IMRU_BIT_SOUND_HI:`IMRU_BIT_SOUND_LO])
        level_out = `IMRU_LVL_4;
      else if (|active_in[`IMRU_BIT_COPIER_DONE:`IMRU_BIT_COPROC])
        level_out = `IMRU_LVL_3;
      else if (active_in[`IMRU_BIT_IO_TIMER])
        level_out = `IMRU_LVL_2;
      else if (|active_in[`IMRU_BIT_SOFT_REQ:`IMRU_BIT_SERIAL_TX])
        level_out = `IMRU_LVL_1;
    end
  end

endmodule

// ### rtl/imru_top.v
`include "imru_defs.vh"

////////////////////////////////////////////////////////////////////////////////
// Operation
// - A mask or pending write sets ones when bit 15 is one, else clears them; zero bits hold.
// - Mask bit 14 is the global gate, an enable with no request source behind it.
// - Bit 13 outside line is level 6; bits 12 disk match and 11 serial rx full are level 5.
// - Sound channel done bits 10 down to 7 are level 4.
// - Bits 6 copier done, 5 vblank start and 4 coprocessor event are level 3.
// - Bit 3 io and timer event is level 2.
// - Bits 2 software request, 1 disk transfer done and 0 serial tx empty are level 1.
// - Pending bits sit at the same positions as their mask bits.
// - Pending bits are always readable, but interrupt only when enabled.
// - Pending bits are never cleared by servicing, only by software writes.
// - Mask is written at 09A and read back at 01C.
// - Pending is written at 09C and read back at 01E.
module imru_top #(
  parameter ADDR_W = 9
) (
  input  wire              clk_in,
  input  wire              reset_n_in,
  input  wire [ADDR_W-1:0] addr_in,
  input  wire [15:0]       wdata_in,
  input  wire              wr_in,
  input  wire              rd_in,
  output reg  [15:0]       rdata_out,
  input  wire [13:0]       event_in,
  output reg  [2:0]        irq_level_out
);

  ////////////////////////////////////////////////////////////////////////////////
  // Set/clear merge, shared by both write ports
  function [15:0] imru_setclr;
    input [15:0] cur;
    input [15:0] wd;
    begin
      if (wd[`IMRU_BIT_POLARITY])
        imru_setclr = cur | {1'b0, wd[14:0]};
      else
        imru_setclr = cur & ~{1'b0, wd[14:0]};
    end
  endfunction

  reg  [14:0] mask_r;
  reg  [14:0] mask_nxt;
  reg  [13:0] pend_r;
  reg  [13:0] pend_nxt;
  wire [15:0] mask_mrg;
  wire [15:0] pend_mrg;
  wire [2:0]  level_w;
  wire        wr_mask;
  wire        wr_pend;

  assign wr_mask  = wr_in && (addr_in == `IMRU_OFS_MASK_WRITE);
  assign wr_pend  = wr_in && (addr_in == `IMRU_OFS_PENDING_WRITE);
  assign mask_mrg = imru_setclr({1'b0, mask_r}, wdata_in);
  assign pend_mrg = imru_setclr({2'b00, pend_r}, wdata_in);

  ////////////////////////////////////////////////////////////////////////////////
  // Next values; bit 14 of the mask has no request bit
  always @* begin
    mask_nxt = mask_r;
    pend_nxt = pend_r;
    if (wr_mask)
      mask_nxt = mask_mrg[14:0];
    if (wr_pend)
      pend_nxt = pend_mrg[13:0];
    // Events OR in last so a same-cycle clear loses; no auto clear on service
    pend_nxt = pend_nxt | event_in;
  end

  // State registers
  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      mask_r <= `IMRU_RST_MASK;
      pend_r <= `IMRU_RST_PENDING;
    end else begin
      mask_r <= mask_nxt;
      pend_r <= pend_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read port: data one cycle after the strobe, zero otherwise
  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rdata_out <= 16'h0000;
    end else if (rd_in) begin
      case (addr_in)
        `IMRU_OFS_MASK_READ:    rdata_out <= {1'b0, mask_r};
        `IMRU_OFS_PENDING_READ: rdata_out <= {2'b00, pend_r};
        default:                rdata_out <= 16'h0000;        // Unmapped reads zero
      endcase
    end else begin
      rdata_out <= 16'h0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Priority encode of enabled pending bits, same positions
  imru_level_encoder u_enc (
    .active_in (pend_r & mask_r[13:0]),
    .gate_in   (mask_r[`IMRU_BIT_GLOBAL_GATE]),
    .level_out (level_w)
  );

  // Registered level output
  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in)
      irq_level_out <= `IMRU_LVL_NONE;
    else
      irq_level_out <= level_w;
  end

endmodule

// ### tb/imru_host_model.sv
// Core side: samples the level each cycle, never touches requests itself
module imru_host_model (
  input  wire       clk_in,
  input  wire       reset_n_in,
  input  wire [2:0] level_in,
  output reg  [2:0] level_seen_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // Servicing only reads the level; clearing is left to software
  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) level_seen_out <= 3'h0;
    else level_seen_out <= level_in;
  end
endmodule

// ### tb/imru_props_properties.sv
////////////////////////////////////////////////////////////////////////////////
// Port-level checks on the mask and request unit
module imru_props #(
  parameter ADDR_W = 9
) (
  input wire              clk_in,
  input wire              reset_n_in,
  input wire [ADDR_W-1:0] addr_in,
  input wire [15:0]       wdata_in,
  input wire              wr_in,
  input wire              rd_in,
  input wire [15:0]       rdata_out,
  input wire [13:0]       event_in,
  input wire [2:0]        irq_level_out
);
  // One domain, so clock and reset are given once
  default clocking @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  AST_RD_IDLE: assert property (!rd_in |=> rdata_out == 16'h0000)
    else $error("read data not zero outside answer");
  AST_MASK_B15: assert property (rd_in && addr_in == 9'h01C |=> !rdata_out[15])
    else $error("mask read shows polarity bit");
  AST_PEND_TOP: assert property (rd_in && addr_in == 9'h01E |=> rdata_out[15:14] == 2'h0)
    else $error("request read shows bits above 13");
  AST_WO_RD: assert property (rd_in && (addr_in == 9'h09A || addr_in == 9'h09C)
    |=> rdata_out == 16'h0000) else $error("write-only address read back");
  AST_LVL_MAX: assert property (irq_level_out <= 3'h6)
    else $error("level above six");
  AST_GATE_OFF: assert property (wr_in && addr_in == 9'h09A && wdata_in[15:14] == 2'h1
    |=> ##1 irq_level_out == 3'h0) else $error("level with gate cleared");
  // Quiet inputs must leave the level alone: nothing clears itself
  AST_HOLD: assert property ((!wr_in && event_in == 14'h0000)[*2]
    |=> $stable(irq_level_out)) else $error("level moved with no cause");
  AST_EVT_SET: assert property (event_in != 14'h0000 ##1 (!wr_in)[*2] ##1
    (rd_in && addr_in == 9'h01E) |=> (rdata_out[13:0] & $past(event_in, 4))
    == $past(event_in, 4)) else $error("event did not set request");
endmodule
bind imru_top imru_props #(.ADDR_W(ADDR_W)) u_props (.clk_in(clk_in),
  .reset_n_in(reset_n_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
  .rd_in(rd_in), .rdata_out(rdata_out), .event_in(event_in), .irq_level_out(irq_level_out));

// ### tb/imru_top_bench.sv
module imru_top_bench;
  timeunit 1ns;
  timeprecision 1ns;
  reg clk_in = 1'h0, reset_n_in = 1'h0, wr_in = 1'h0, rd_in = 1'h0;
  reg  [8:0]  addr_in = 9'h000;
  reg  [15:0] wdata_in = 16'h0000;
  reg  [13:0] event_in = 14'h0000;
  wire [15:0] rdata_out;
  wire [2:0]  irq_level_out, seen;
  int num_errors = 0, n_tests = 0;
  initial forever #10 clk_in = ~clk_in;
  imru_top dut_u (.clk_in(clk_in), .reset_n_in(reset_n_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .event_in(event_in), .irq_level_out(irq_level_out));
  imru_host_model host_u (.clk_in(clk_in), .reset_n_in(reset_n_in),
    .level_in(irq_level_out), .level_seen_out(seen));
  ////////////////////////////////////////////////////////////////////////////////
  task chk(input string nm, input [15:0] got, input [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Events ride along with the write so a clear can meet them in one cycle
  task wr(input [8:0] a, input [15:0] d, input [13:0] e);
    @(posedge clk_in);
    addr_in <= a; wdata_in <= d; wr_in <= 1'h1; event_in <= e;
    @(posedge clk_in);
    wr_in <= 1'h0; event_in <= 14'h0000;
  endtask
  task rd(input [8:0] a, input [15:0] e);
    @(posedge clk_in);
    addr_in <= a; rd_in <= 1'h1;
    @(posedge clk_in);
    rd_in <= 1'h0;
    @(negedge clk_in);
    chk("rdata", rdata_out, e);
  endtask
  task lv(input [2:0] e);
    @(posedge clk_in);
    @(negedge clk_in);
    chk("level", {13'h0000, irq_level_out}, {13'h0000, e});
  endtask
  function [2:0] lvl_of(input int i);
    lvl_of = i == 13 ? 3'h6 : i >= 11 ? 3'h5 : i >= 7 ? 3'h4 :
             i >= 4 ? 3'h3 : i == 3 ? 3'h2 : 3'h1;
  endfunction
  task print_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Fixed latencies only, so one overall limit guards against a hang
  initial begin
    #1000000;
    num_errors++;
    print_verdict;
  end
  initial begin
    repeat (20) @(posedge clk_in);
    reset_n_in <= 1'h1;
    rd(9'h01C, 16'h0000);
    rd(9'h01E, 16'h0000);
    wr(9'h09A, 16'hC001, 14'h0000);
    rd(9'h01C, 16'h4001);
    wr(9'h01C, 16'hFFFF, 14'h0000);
    rd(9'h01C, 16'h4001);
    wr(9'h09A, 16'h0001, 14'h0000);
    rd(9'h01C, 16'h4000);
    wr(9'h09A, 16'hFFFF, 14'h0000);
    rd(9'h09A, 16'h0000);
    $display("register test done");
    for (int i = 0; i < 14; i++) begin
      wr(9'h09C, 16'h7FFF, 14'h0000);
      wr(9'h000, 16'hFFFF, 14'h0001 << i);
      lv(lvl_of(i));
      rd(9'h01E, 16'h0001 << i);
    end
    $display("source test done");
    wr(9'h09A, 16'h4000, 14'h0000);
    lv(3'h0);
    repeat (5) @(posedge clk_in);
    rd(9'h01E, 16'h2000);
    wr(9'h09C, 16'h2008, 14'h0008);
    rd(9'h01E, 16'h0008);
    wr(9'h09C, 16'h8004, 14'h0000);
    rd(9'h01E, 16'h000C);
    wr(9'h09A, 16'hC000, 14'h0000);
    lv(3'h2);
    @(posedge clk_in);
    @(negedge clk_in);
    chk("seen", {13'h0000, seen}, 16'h0002);
    $display("gate test done");
    print_verdict;
  end
endmodule
